/* hdl/dsss_pkg.sv */
package dsss_pkg;
	// ************************************************************
	// Start methods
	// ************************************************************
	localparam logic [3:0] START_NORMAL     = 4'h1;
	localparam logic [3:0] START_POWER_UP   = 4'h2;
	localparam logic [3:0] START_DC_BRAKE   = 4'h3;
	localparam logic [3:0] START_AUTO_DC    = 4'h4;
	localparam logic [3:0] START_FLY_LOW    = 4'h5;
	localparam logic [3:0] START_FLY_MED    = 4'h6;
	localparam logic [3:0] START_FLY_HIGH   = 4'h7;
	// ************************************************************
	// Stop methods
	// ************************************************************
	localparam logic [3:0] STOP_COAST       = 4'h1;
	localparam logic [3:0] STOP_COAST_DC    = 4'h2;
	localparam logic [3:0] STOP_RAMP        = 4'h3;
	localparam logic [3:0] STOP_RAMP_DC     = 4'h4;
	// ************************************************************
	// Standard speed sources
	// ************************************************************
	localparam logic [3:0] SRC_KEYPAD       = 4'h1;
	localparam logic [3:0] SRC_PRESET1      = 4'h2;
	localparam logic [3:0] SRC_VOLT         = 4'h3;
	localparam logic [3:0] SRC_CURRENT      = 4'h4;
	// ************************************************************
	// Status switch selections
	// ************************************************************
	localparam logic [3:0] STAT_NONE        = 4'h1;
	localparam logic [3:0] STAT_RUN         = 4'h2;
	localparam logic [3:0] STAT_FAULT       = 4'h3;
	localparam logic [3:0] STAT_INV_FAULT   = 4'h4;
	localparam logic [3:0] STAT_LOCKOUT     = 4'h5;
	localparam logic [3:0] STAT_AT_SPEED    = 4'h6;
	localparam logic [3:0] STAT_ABOVE_P3    = 4'h7;
	localparam logic [3:0] STAT_CUR_LIMIT   = 4'h8;
	localparam logic [3:0] STAT_AUTO_MODE   = 4'h9;
	localparam logic [3:0] STAT_REVERSE     = 4'ha;
	// ************************************************************
	// Multifunction input selections
	// ************************************************************
	localparam logic [3:0] MFI_RUN_REV      = 4'h5;
	localparam logic [3:0] MFI_START_REV    = 4'h6;
	localparam logic [3:0] MFI_EXT_FAULT    = 4'h7;
	localparam logic [3:0] MFI_AUX_STOP     = 4'ha;
	// ************************************************************
	// Timing and counts
	// ************************************************************
	localparam int CLK_MHZ          = 125;
	localparam int AUTO_DC_GAP_S    = 15;
	localparam int FLY_GAP_S        = 2;
	localparam int COAST_DC_MAX_S   = 2;
	localparam int AUTO_DC_GAP_CYC  = AUTO_DC_GAP_S * CLK_MHZ * 1000000;
	localparam int FLY_GAP_CYC      = FLY_GAP_S * CLK_MHZ * 1000000;
	localparam int COAST_DC_MAX_CYC = COAST_DC_MAX_S * CLK_MHZ * 1000000;
	localparam logic [1:0] RESTART_TRIES = 2'h3;
	// Frequencies in tenths of Hz
	localparam logic [15:0] BRAKE_FREQ_DHZ = 16'h0002;
	localparam logic [15:0] AT_SPEED_DHZ   = 16'h0005;
	localparam logic [15:0] FREQ_STEP_DHZ  = 16'h0001;
endpackage : dsss_pkg

/* hdl/dsss_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module dsss_sequencer
	import dsss_pkg::*;
#(
	parameter int AUTO_DC_GAP  = AUTO_DC_GAP_CYC,
	parameter int FLY_GAP      = FLY_GAP_CYC,
	parameter int COAST_DC_MAX = COAST_DC_MAX_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  start_method,
	input  wire logic [3:0]  stop_method,
	input  wire logic [3:0]  speed_source,
	input  wire logic [3:0]  status_select,
	input  wire logic [3:0]  mfi_select,
	input  wire logic        both_directions,
	input  wire logic        forward_run_input,
	input  wire logic        stop_contact_input,
	input  wire logic        multifunction_input_a,
	input  wire logic        keypad_start,
	input  wire logic        keypad_stop,
	input  wire logic        drive_fault,
	input  wire logic        manual_reset,
	input  wire logic        auto_ref_active,
	input  wire logic [31:0] dc_brake_cycles,
	input  wire logic [15:0] keypad_speed,
	input  wire logic [15:0] preset_speed_1,
	input  wire logic [15:0] preset_speed_3,
	input  wire logic [15:0] volt_speed,
	input  wire logic [15:0] current_speed,
	input  wire logic [15:0] output_freq,
	input  wire logic [15:0] output_current,
	input  wire logic [15:0] current_limit,
	output logic             motor_enable,
	output logic             dc_brake,
	output logic             ramp_down,
	output logic             use_second_ramp,
	output logic             spinning_load_catch,
	output logic [1:0]       catch_level,
	output logic             reverse,
	output logic [15:0]      speed_setpoint,
	output logic             start_pending_indication,
	output logic             lockout_indication,
	output logic             restart_exhausted_state,
	output logic             status_switch_output
);
	typedef enum {
		S_IDLE, S_PRE_BRAKE, S_RUN, S_RAMP, S_GAP, S_STOP_BRAKE,
		S_FAULT, S_WAIT, S_LOCK
	} dsss_phase_t;

	typedef struct packed {
		dsss_phase_t phase;
		logic [1:0]  tries;
		logic        powered;
		logic        restarting;
		logic        mfi_prev;
		logic        rev_latch;
		logic        motor_enable;
		logic        dc_brake;
		logic        ramp_down;
		logic        second_ramp;
		logic        catch_on;
		logic [1:0]  catch_level;
		logic        reverse;
		logic [15:0] setpoint;
		logic        pending;
		logic        lock;
		logic        sw;
	} dsss_state_t;

	dsss_state_t st;
	dsss_state_t next_st;
	dsss_timer_if tif();

	dsss_timer u_timer (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.tif      (tif)
	);

	// Auto modes need the run contact held closed by the outside
	function automatic logic is_auto(input logic [3:0] m);
		is_auto = (m >= START_AUTO_DC) && (m <= START_FLY_HIGH);
	endfunction

	function automatic logic is_fly(input logic [3:0] m);
		is_fly = (m >= START_FLY_LOW) && (m <= START_FLY_HIGH);
	endfunction

	// ************************************************************
	// Input decode
	// ************************************************************
	logic mfi_on;
	logic ext_fault;
	logic aux_stop;
	logic rev_mode;
	logic start_cmd;
	logic stop_cmd;
	logic fault_any;
	logic [15:0] diff;

	always_comb begin
		// Codes 7 and 10 act on opening, others on closure
		if (mfi_select == MFI_EXT_FAULT || mfi_select == MFI_AUX_STOP) begin
			mfi_on = !multifunction_input_a;
		end else begin
			mfi_on = multifunction_input_a;
		end
		ext_fault = mfi_on && (mfi_select == MFI_EXT_FAULT);
		aux_stop  = mfi_on && (mfi_select == MFI_AUX_STOP);
		rev_mode  = both_directions && (mfi_select == MFI_RUN_REV
			|| mfi_select == MFI_START_REV);
		start_cmd = forward_run_input || keypad_start
			|| (rev_mode && mfi_on && !st.mfi_prev);
		stop_cmd  = !stop_contact_input || keypad_stop || aux_stop;
		// Run reverse makes the forward input a maintained run
		if (rev_mode && mfi_select == MFI_RUN_REV) begin
			stop_cmd = stop_cmd || !(forward_run_input || mfi_on);
		end
		fault_any = drive_fault || ext_fault;
		diff = (output_freq > st.setpoint) ? output_freq - st.setpoint
			: st.setpoint - output_freq;
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb begin
		next_st          = st;
		next_st.mfi_prev = mfi_on;
		next_st.powered  = 1'b1;
		tif.load         = 1'b0;
		tif.count        = dc_brake_cycles;
		// Speed source selection
		unique case (speed_source)
			SRC_PRESET1: next_st.setpoint = preset_speed_1;
			SRC_VOLT:    next_st.setpoint = volt_speed;
			SRC_CURRENT: next_st.setpoint = current_speed;
			default:     next_st.setpoint = keypad_speed;
		endcase
		if (rev_mode && mfi_on && !st.mfi_prev) begin
			next_st.rev_latch = 1'b1;
		end else if (rev_mode && forward_run_input) begin
			next_st.rev_latch = 1'b0;
		end
		unique case (st.phase)
			S_IDLE: begin
				// Power up starts codes 02 and 04-07
				if ((!st.powered && (start_method == START_POWER_UP
					|| is_auto(start_method))) || start_cmd) begin
					next_st.restarting = !st.powered;
					if (start_method == START_DC_BRAKE
						|| start_method == START_AUTO_DC) begin
						next_st.phase = S_PRE_BRAKE;
						tif.load = 1'b1;
					end else begin
						next_st.phase = S_RUN;
					end
				end
			end
			S_PRE_BRAKE: begin
				if (tif.done) begin
					next_st.phase = S_RUN;
				end
			end
			S_RUN: begin
				if (st.restarting && !fault_any) begin
					next_st.tries = 2'h0;
					next_st.restarting = 1'b0;
				end
				if (fault_any) begin
					next_st.phase = S_FAULT;
				end else if (aux_stop) begin
					next_st.phase = S_RAMP;
				end else if (stop_cmd) begin
					unique case (stop_method)
						STOP_COAST_DC: begin
							next_st.phase = S_GAP;
							tif.count = 32'(COAST_DC_MAX);
							tif.load = 1'b1;
						end
						STOP_RAMP, STOP_RAMP_DC: begin
							next_st.phase = S_RAMP;
						end
						default: begin
							next_st.phase = S_IDLE;
						end
					endcase
				end
			end
			S_RAMP: begin
				if (fault_any) begin
					next_st.phase = S_FAULT;
				end else if (output_freq <= BRAKE_FREQ_DHZ
					&& stop_method == STOP_RAMP_DC && !aux_stop) begin
					next_st.phase = S_STOP_BRAKE;
					tif.load = 1'b1;
				end else if (output_freq == 16'h0) begin
					next_st.phase = S_IDLE;
				end
			end
			S_GAP: begin
				// Fixed worst-case delay before braking
				if (tif.done) begin
					next_st.phase = S_STOP_BRAKE;
					tif.load = 1'b1;
				end
			end
			S_STOP_BRAKE: begin
				if (tif.done) begin
					next_st.phase = S_IDLE;
				end
			end
			S_FAULT: begin
				if (manual_reset) begin
					next_st.phase = S_IDLE;
					next_st.tries = 2'h0;
				end else if (!is_auto(start_method)) begin
					next_st.phase = S_FAULT;
				end else if (st.tries == RESTART_TRIES) begin
					next_st.phase = S_LOCK;
				end else begin
					next_st.phase = S_WAIT;
					next_st.tries = st.tries + 2'h1;
					tif.count = (start_method == START_AUTO_DC)
						? 32'(AUTO_DC_GAP) : 32'(FLY_GAP);
					tif.load = 1'b1;
				end
			end
			S_WAIT: begin
				if (manual_reset) begin
					next_st.phase = S_IDLE;
					next_st.tries = 2'h0;
				end else if (tif.done && !fault_any) begin
					next_st.restarting = 1'b1;
					if (start_method == START_AUTO_DC) begin
						next_st.phase = S_PRE_BRAKE;
						tif.load = 1'b1;
					end else begin
						next_st.phase = S_RUN;
					end
				end else if (tif.done) begin
					next_st.phase = S_FAULT;
				end
			end
			S_LOCK: begin
				if (manual_reset) begin
					next_st.phase = S_IDLE;
					next_st.tries = 2'h0;
				end
			end
		endcase
		// Power stage commands; enable, brake and ramp from the next phase
		next_st.motor_enable = (next_st.phase == S_RUN)
			|| (next_st.phase == S_RAMP);
		next_st.dc_brake = (next_st.phase == S_PRE_BRAKE)
			|| (next_st.phase == S_STOP_BRAKE);
		next_st.ramp_down = (next_st.phase == S_RAMP);
		next_st.second_ramp = aux_stop;
		next_st.catch_on = (next_st.phase == S_RUN) && next_st.restarting
			&& is_fly(start_method);
		next_st.catch_level = 2'(start_method - START_FLY_LOW);
		next_st.reverse = rev_mode && (mfi_select == MFI_RUN_REV ? mfi_on
			: next_st.rev_latch);
		next_st.pending = (next_st.phase == S_WAIT);
		next_st.lock = (next_st.phase == S_LOCK);
		// Status switch selection
		unique case (status_select)
			STAT_RUN:       next_st.sw = next_st.motor_enable;
			STAT_FAULT:     next_st.sw = !fault_any;
			STAT_INV_FAULT: next_st.sw = fault_any;
			STAT_LOCKOUT:   next_st.sw = !next_st.lock;
			STAT_AT_SPEED:  next_st.sw = diff <= AT_SPEED_DHZ;
			STAT_ABOVE_P3:  next_st.sw = output_freq > preset_speed_3;
			STAT_CUR_LIMIT: next_st.sw = output_current > current_limit;
			STAT_AUTO_MODE: next_st.sw = auto_ref_active;
			STAT_REVERSE:   next_st.sw = next_st.reverse;
			default:        next_st.sw = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st <= '{phase: S_IDLE, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign motor_enable             = st.motor_enable;
	assign dc_brake                 = st.dc_brake;
	assign ramp_down                = st.ramp_down;
	assign use_second_ramp          = st.second_ramp;
	assign spinning_load_catch      = st.catch_on;
	assign catch_level              = st.catch_level;
	assign reverse                  = st.reverse;
	assign speed_setpoint           = st.setpoint;
	assign start_pending_indication = st.pending;
	assign lockout_indication       = st.lock;
	assign restart_exhausted_state  = st.lock;
	assign status_switch_output     = st.sw;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_brake_not_run;
		@(posedge core_clk) disable iff (sys_rst)
		dc_brake |-> !motor_enable;
	endproperty
	a_brake_not_run: assert property (p_brake_not_run)
		else $error("brake and motor on together");

	property p_run_brake;
		@(posedge core_clk) disable iff (sys_rst)
		$past(status_select) == STAT_RUN && dc_brake
			|-> !status_switch_output;
	endproperty
	a_run_brake: assert property (p_run_brake)
		else $error("run status closed while braking");

	property p_lock_ind;
		@(posedge core_clk) disable iff (sys_rst)
		lockout_indication |-> !start_pending_indication && !motor_enable;
	endproperty
	a_lock_ind: assert property (p_lock_ind)
		else $error("lockout with drive active");

	property p_lock_stays;
		@(posedge core_clk) disable iff (sys_rst)
		lockout_indication && !manual_reset |=> lockout_indication;
	endproperty
	a_lock_stays: assert property (p_lock_stays)
		else $error("lockout left without reset");

	property p_pending;
		@(posedge core_clk) disable iff (sys_rst)
		$rose(start_pending_indication) |-> $past(st.phase) == S_FAULT;
	endproperty
	a_pending: assert property (p_pending)
		else $error("pending not from fault");

	property p_coast;
		@(posedge core_clk) disable iff (sys_rst)
		st.phase == S_RUN && stop_cmd && !fault_any && !aux_stop
			&& stop_method == STOP_COAST |=> !motor_enable && !dc_brake;
	endproperty
	a_coast: assert property (p_coast)
		else $error("coast stop kept output");

	property p_ramp;
		@(posedge core_clk) disable iff (sys_rst)
		st.phase == S_RUN && stop_cmd && !fault_any
			&& stop_method == STOP_RAMP |=> ramp_down && motor_enable;
	endproperty
	a_ramp: assert property (p_ramp)
		else $error("ramp stop not ramping");

	property p_stat_fault;
		@(posedge core_clk) disable iff (sys_rst)
		status_select == STAT_FAULT |=> status_switch_output == !$past(fault_any);
	endproperty
	a_stat_fault: assert property (p_stat_fault)
		else $error("fault status wrong");

	property p_above;
		@(posedge core_clk) disable iff (sys_rst)
		status_select == STAT_ABOVE_P3 && output_freq == preset_speed_3
			|=> !status_switch_output;
	endproperty
	a_above: assert property (p_above)
		else $error("above preset closed at equal");
endmodule : dsss_sequencer
`default_nettype wire

/* hdl/dsss_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Countdown timer; done pulses one cycle when count reaches zero
module dsss_timer (
	input  wire logic   core_clk,
	input  wire logic   sys_rst,
	dsss_timer_if.tmr   tif
);
	typedef struct packed {
		logic [31:0] left;
		logic        busy;
		logic        done;
	} dsss_tmr_state_t;

	dsss_tmr_state_t st;
	dsss_tmr_state_t next_st;

	// ************************************************************
	// Count logic
	// ************************************************************
	always_comb begin
		next_st      = st;
		next_st.done = 1'b0;
		if (tif.load) begin
			next_st.left = (tif.count == 32'h0) ? 32'h1 : tif.count;
			next_st.busy = 1'b1;
		end else if (st.busy) begin
			if (st.left == 32'h1) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end
			next_st.left = st.left - 32'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tif.busy = st.busy;
	assign tif.done = st.done;
endmodule : dsss_timer
`default_nettype wire

/* hdl/dsss_timer_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Countdown request and status between sequencer and timer
interface dsss_timer_if;
	logic        load;
	logic [31:0] count;
	logic        busy;
	logic        done;
	modport seq (output load, output count, input busy, input done);
	modport tmr (input load, input count, output busy, output done);
endinterface : dsss_timer_if
`default_nettype wire

/* verification/drive_start_stop_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module drive_start_stop_sequencer_tb
	import dsss_pkg::*;
;
	localparam int GA = 20;
	localparam int GF = 10;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  start_method = START_NORMAL;
	logic [3:0]  stop_method = STOP_COAST;
	logic [3:0]  speed_source = SRC_PRESET1;
	logic [3:0]  status_select = STAT_NONE;
	logic [3:0]  mfi_select = 4'h1;
	logic        both_directions = 1'b0;
	logic        forward_run_input = 1'b0;
	logic        stop_contact_input = 1'b1;
	logic        multifunction_input_a = 1'b1;
	logic        keypad_start = 1'b0;
	logic        keypad_stop = 1'b0;
	logic        drive_fault = 1'b0;
	logic        manual_reset = 1'b0;
	logic        auto_ref_active = 1'b0;
	logic [31:0] dc_brake_cycles = 32'h0000_0005;
	logic [15:0] keypad_speed = 16'h0011;
	logic [15:0] preset_speed_1 = 16'h000a;
	logic [15:0] preset_speed_3 = 16'h0009;
	logic [15:0] volt_speed = 16'h0033;
	logic [15:0] current_speed = 16'h0044;
	logic [15:0] output_current = 16'h0010;
	logic [15:0] current_limit = 16'h0010;
	logic [15:0] output_freq;
	logic [15:0] speed_setpoint;
	logic        motor_enable;
	logic        dc_brake;
	logic        ramp_down;
	logic        use_second_ramp;
	logic        spinning_load_catch;
	logic [1:0]  catch_level;
	logic        reverse;
	logic        start_pending_indication;
	logic        lockout_indication;
	logic        restart_exhausted_state;
	logic        status_switch_output;
	logic [15:0] src_tab [4] = '{16'h0011, 16'h000a, 16'h0033, 16'h0044};
	logic        pend_q = 1'b0;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          n_pend = 0;
	int          n;
	int          base;

	dsss_sequencer #(.AUTO_DC_GAP(GA), .FLY_GAP(GF), .COAST_DC_MAX(5)) u_dut (
		.core_clk, .sys_rst, .start_method, .stop_method, .speed_source,
		.status_select, .mfi_select, .both_directions, .forward_run_input,
		.stop_contact_input, .multifunction_input_a, .keypad_start,
		.keypad_stop, .drive_fault, .manual_reset, .auto_ref_active,
		.dc_brake_cycles, .keypad_speed, .preset_speed_1, .preset_speed_3,
		.volt_speed, .current_speed, .output_freq, .output_current,
		.current_limit, .motor_enable, .dc_brake, .ramp_down,
		.use_second_ramp, .spinning_load_catch, .catch_level, .reverse,
		.speed_setpoint, .start_pending_indication, .lockout_indication,
		.restart_exhausted_state, .status_switch_output
	);
	dsss_stage_model u_stage (.core_clk, .sys_rst, .motor_enable,
		.ramp_down, .speed_setpoint, .output_freq);

	// 8 ns clock
	always #4 core_clk = ~core_clk;

	// Count rises of the pending indication
	always @(posedge core_clk) begin
		pend_q <= start_pending_indication;
		if (start_pending_indication === 1'b1 && pend_q === 1'b0) begin
			n_pend <= n_pend + 1;
		end
	end

	// ****************************
	// Helpers
	// ****************************
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic samp(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return motor_enable;
			1: return dc_brake;
			2: return start_pending_indication;
			3: return lockout_indication;
			default: return spinning_load_catch;
		endcase
	endfunction

	// Bounded wait on one output; c gives the cycles spent
	task automatic wt(input int s, input logic v, output int c);
		c = 0;
		#1;
		while (sig(s) !== v && c < 400) begin
			samp(1);
			c++;
		end
		if (c >= 400) begin
			n_mismatch++;
			$display("ERROR wait %0d expected %b seen %b", s, v, sig(s));
		end
	endtask

	task automatic st(input logic [3:0] code, input logic e);
		@(posedge core_clk);
		status_select <= code;
		samp(3);
		chk("status_switch_output", status_switch_output, e);
	endtask

	// One-cycle fault, then time the pending interval
	task automatic restart(input int gap);
		int c;
		@(posedge core_clk);
		drive_fault <= 1'b1;
		@(posedge core_clk);
		drive_fault <= 1'b0;
		wt(2, 1'b1, c);
		wt(2, 1'b0, c);
		chk("restart_gap", 32'(c >= gap && c <= gap + 1), 1);
	endtask

	// Coast to idle; both contacts back to rest
	task automatic halt();
		@(posedge core_clk);
		stop_method <= STOP_COAST;
		stop_contact_input <= 1'b0;
		forward_run_input <= 1'b0;
		samp(3);
		@(posedge core_clk);
		stop_contact_input <= 1'b1;
	endtask

	task automatic pulse_reset();
		@(posedge core_clk);
		manual_reset <= 1'b1;
		@(posedge core_clk);
		manual_reset <= 1'b0;
	endtask

	task automatic report_and_stop();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles used
	initial begin
		#160000;
		n_mismatch++;
		report_and_stop();
	end

	// ****************************
	// Scenarios
	// ****************************
	initial begin
		samp(3);
		chk("motor_enable", motor_enable, 0);
		@(posedge core_clk);
		sys_rst <= 1'b0;
		samp(8);
		chk("motor_enable", motor_enable, 0);
		@(posedge core_clk);
		keypad_start <= 1'b1;
		@(posedge core_clk);
		keypad_start <= 1'b0;
		wt(0, 1'b1, n);
		chk("key_start", 32'(n <= 2), 1);
		for (int i = 1; i <= 4; i++) begin
			@(posedge core_clk);
			speed_source <= 4'(i);
			samp(3);
			chk("speed_setpoint", speed_setpoint, src_tab[i - 1]);
		end
		@(posedge core_clk);
		speed_source <= SRC_PRESET1;
		samp(20);
		st(STAT_RUN, 1'b1);
		st(STAT_ABOVE_P3, 1'b1);
		@(posedge core_clk);
		preset_speed_3 <= 16'h000a;
		st(STAT_ABOVE_P3, 1'b0);
		st(STAT_CUR_LIMIT, 1'b0);
		@(posedge core_clk);
		output_current <= 16'h0011;
		st(STAT_CUR_LIMIT, 1'b1);
		st(STAT_AUTO_MODE, 1'b0);
		@(posedge core_clk);
		auto_ref_active <= 1'b1;
		st(STAT_AUTO_MODE, 1'b1);
		st(STAT_FAULT, 1'b1);
		st(STAT_INV_FAULT, 1'b0);
		st(STAT_AT_SPEED, 1'b1);
		// Setpoint jump: the slewing stage falls out of the band
		@(posedge core_clk);
		preset_speed_1 <= 16'h0014;
		samp(4);
		chk("at_speed_off", status_switch_output, 0);
		samp(16);
		chk("at_speed_on", status_switch_output, 1);
		@(posedge core_clk);
		keypad_stop <= 1'b1;
		@(posedge core_clk);
		keypad_stop <= 1'b0;
		samp(0);
		chk("coast_motor", motor_enable, 0);
		chk("coast_ramp", ramp_down, 0);
		// Ramp down, brake near standstill
		@(posedge core_clk);
		stop_method <= STOP_RAMP_DC;
		status_select <= STAT_RUN;
		forward_run_input <= 1'b1;
		samp(30);
		@(posedge core_clk);
		stop_contact_input <= 1'b0;
		forward_run_input <= 1'b0;
		samp(2);
		chk("ramp_down", ramp_down, 1);
		wt(1, 1'b1, n);
		chk("brake_freq", 32'(output_freq <= BRAKE_FREQ_DHZ), 1);
		chk("ramp_len", 32'(n >= 16), 1);
		samp(1);
		chk("run_in_brake", status_switch_output, 0);
		wt(1, 1'b0, n);
		chk("brake_len", 32'(n >= 4 && n <= 7), 1);
		halt();
		// Coast first, brake within the bounded delay
		@(posedge core_clk);
		stop_method <= STOP_COAST_DC;
		forward_run_input <= 1'b1;
		wt(0, 1'b1, n);
		@(posedge core_clk);
		stop_contact_input <= 1'b0;
		forward_run_input <= 1'b0;
		samp(1);
		chk("coast_dc_motor", motor_enable, 0);
		wt(1, 1'b1, n);
		chk("coast_dc_delay", 32'(n <= 7), 1);
		halt();
		@(posedge core_clk);
		start_method <= START_DC_BRAKE;
		forward_run_input <= 1'b1;
		samp(1);
		chk("pre_brake", dc_brake, 1);
		chk("pre_motor", motor_enable, 0);
		wt(0, 1'b1, n);
		chk("pre_brake_len", 32'(n >= 4), 1);
		chk("brake_off", dc_brake, 0);
		// Plain ramp stop: no brake, ends at standstill
		samp(20);
		@(posedge core_clk);
		stop_method <= STOP_RAMP;
		stop_contact_input <= 1'b0;
		forward_run_input <= 1'b0;
		samp(2);
		chk("ramp_only", ramp_down, 1);
		wt(0, 1'b0, n);
		chk("ramp_no_brake", dc_brake, 0);
		chk("ramp_end_freq", output_freq, 0);
		halt();
		// Second reset with the run contact held closed
		@(posedge core_clk);
		start_method <= START_POWER_UP;
		forward_run_input <= 1'b1;
		sys_rst <= 1'b1;
		samp(3);
		@(posedge core_clk);
		sys_rst <= 1'b0;
		wt(0, 1'b1, n);
		chk("power_up", 32'(n <= 3), 1);
		st(STAT_LOCKOUT, 1'b1);
		for (int c = 5; c <= 7; c++) begin
			@(posedge core_clk);
			start_method <= 4'(c);
			restart(GF);
			wt(4, 1'b1, n);
			chk("catch_level", catch_level, c - 5);
			wt(0, 1'b1, n);
			samp(4);
		end
		// Fault held: every restart fails
		base = n_pend;
		@(posedge core_clk);
		drive_fault <= 1'b1;
		wt(3, 1'b1, n);
		chk("tries", n_pend - base, 3);
		chk("exhausted", restart_exhausted_state, 1);
		samp(2);
		chk("lockout_sw", status_switch_output, 0);
		@(posedge core_clk);
		drive_fault <= 1'b0;
		samp(40);
		chk("lockout_held", lockout_indication, 1);
		pulse_reset();
		samp(2);
		chk("lockout_clr", lockout_indication, 0);
		halt();
		@(posedge core_clk);
		start_method <= START_AUTO_DC;
		forward_run_input <= 1'b1;
		samp(1);
		chk("auto_dc_start", dc_brake, 1);
		wt(0, 1'b1, n);
		restart(GA);
		wt(1, 1'b1, n);
		chk("auto_dc_restart", 32'(n <= 3), 1);
		wt(0, 1'b1, n);
		samp(20);
		// Auxiliary stop ramps even with coast selected
		@(posedge core_clk);
		stop_method <= STOP_COAST;
		mfi_select <= MFI_AUX_STOP;
		samp(2);
		@(posedge core_clk);
		multifunction_input_a <= 1'b0;
		samp(2);
		chk("aux_ramp", ramp_down, 1);
		chk("aux_second", use_second_ramp, 1);
		chk("aux_motor", motor_enable, 1);
		@(posedge core_clk);
		multifunction_input_a <= 1'b1;
		halt();
		@(posedge core_clk);
		mfi_select <= MFI_EXT_FAULT;
		st(STAT_INV_FAULT, 1'b0);
		@(posedge core_clk);
		multifunction_input_a <= 1'b0;
		st(STAT_INV_FAULT, 1'b1);
		@(posedge core_clk);
		multifunction_input_a <= 1'b1;
		pulse_reset();
		@(posedge core_clk);
		start_method <= START_NORMAL;
		multifunction_input_a <= 1'b0;
		mfi_select <= MFI_RUN_REV;
		both_directions <= 1'b1;
		st(STAT_REVERSE, 1'b0);
		@(posedge core_clk);
		multifunction_input_a <= 1'b1;
		wt(0, 1'b1, n);
		samp(2);
		chk("reverse", reverse, 1);
		chk("rev_sw", status_switch_output, 1);
		@(posedge core_clk);
		multifunction_input_a <= 1'b0;
		samp(2);
		chk("rev_stop", motor_enable, 0);
		// Momentary reverse start, momentary stop
		@(posedge core_clk);
		mfi_select <= MFI_START_REV;
		@(posedge core_clk);
		multifunction_input_a <= 1'b1;
		@(posedge core_clk);
		multifunction_input_a <= 1'b0;
		samp(3);
		chk("start_rev", reverse, 1);
		chk("start_rev_run", motor_enable, 1);
		@(posedge core_clk);
		stop_contact_input <= 1'b0;
		@(posedge core_clk);
		stop_contact_input <= 1'b1;
		samp(0);
		chk("start_rev_stop", motor_enable, 0);
		// Forward only: reverse input is ignored
		@(posedge core_clk);
		both_directions <= 1'b0;
		multifunction_input_a <= 1'b1;
		samp(3);
		chk("fwd_only", motor_enable, 0);
		report_and_stop();
	end
endmodule // drive_start_stop_sequencer_tb
`default_nettype wire

/* verification/dsss_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Power stage stand-in: output frequency slews toward the setpoint
module dsss_stage_model
	import dsss_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        motor_enable,
	input  wire logic        ramp_down,
	input  wire logic [15:0] speed_setpoint,
	output logic      [15:0] output_freq
);
	// ****************************
	// Frequency slew
	// ****************************
	// One step a cycle, so ramps are slow enough to watch thresholds
	always_ff @(posedge core_clk) begin
		if (sys_rst || !motor_enable) begin
			output_freq <= 16'h0000;
		end else if (ramp_down) begin
			if (output_freq != 16'h0000) begin
				output_freq <= output_freq - FREQ_STEP_DHZ;
			end
		end else if (output_freq < speed_setpoint) begin
			output_freq <= output_freq + FREQ_STEP_DHZ;
		end else if (output_freq > speed_setpoint) begin
			output_freq <= output_freq - FREQ_STEP_DHZ;
		end
	end
endmodule // dsss_stage_model
`default_nettype wire
